// [adc_conversion_control.v]
// converter control: axi4-lite registers, clock divider, conversion sequencer
// Notes on behaviour
// RULE1: analog enable routes pin to converter mux, disables other pin uses
// RULE2: register pull-up disconnected while pin is analog input
// RULE3: analog enable overrides the pin direction control
// RULE4: reference select picks reference pin when set, supply otherwise
// RULE5: divide field sets conversion clock /1../64; code 111 undefined
// RULE6: power-off bit clear enables converter; set switches it off
// RULE7: five-bit channel select split over the two control registers
// RULE8: interrupt out only when global and converter enables both set
// RULE9: start pulse zero-one-zero begins a conversion
// RULE10: start held high keeps converter reset and busy flag high
// RULE11: busy high while converting, low at completion, result readable
// RULE12: conversion lasts sixteen conversion clock periods
// RULE13: conversion runs in hardware without processor help
// RULE14: irq flag set at every conversion end regardless of enables
// RULE15: result is unsigned 12-bit, full scale at reference
// RULE16: model result is input times 4096 over reference, saturated
// RULE17: software polls busy flag or uses irq with stack room
// RULE18: result registers hold last value until next completion
// RULE19: powered off, start does nothing and busy flag unchanged
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defines.vh"
module adc_conversion_control #(
    parameter PINS = 12,
    parameter RES_W = 12
) (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [RES_W-1:0] analog_sample_i,
    input wire [RES_W-1:0] reference_pin_level_i,
    input wire [RES_W-1:0] supply_level_i,
    output reg [PINS-1:0] analog_pin_enable_o,
    output reg [PINS-1:0] pin_dir_input_o,
    output reg [PINS-1:0] pullup_enable_o,
    output reg [PINS-1:0] digital_func_enable_o,
    output reg reference_select_o,
    output reg ref_pin_other_func_en_o,
    output reg [4:0] channel_select_o,
    output reg converter_power_off_o,
    output reg converter_reset_o,
    output reg sample_strobe_o,
    output reg conv_clk_tick_o,
    output wire irq_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_CONV = 2'h2;
    localparam [RES_W-1:0] FULL = {RES_W{1'b1}};

    // control registers
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg [PINS-1:0] pin_en_q;
    reg [PINS-1:0] port_dir_q;
    reg [PINS-1:0] pullup_q;
    reg irq_flag_q;
    reg conv_irq_en_q;
    reg global_irq_en_q;
    reg [RES_W-1:0] result_q;
    reg [1:0] state_q;
    reg busy_q;
    reg [6:0] div_cnt_q;
    reg [4:0] period_q;
    reg irq_set;
    reg [RES_W-1:0] conv_value;
    reg [RES_W-1:0] ref_level;
    reg [2*RES_W-1:0] scaled;

    // bus side
    reg [7:0] aw_q;
    reg aw_have_q;
    reg [31:0] w_q;
    reg [3:0] ws_q;
    reg w_have_q;
    wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready = ~w_have_q;
    assign s_axi_arready = ~s_axi_rvalid;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

    function known_offset;
        input [7:0] a;
        begin
            case (a)
                `OFS_CTRL0, `OFS_CTRL1, `OFS_PIN_LO, `OFS_PIN_HI,
                `OFS_IRQ, `OFS_RES_LO, `OFS_RES_HI, `OFS_PORT_DIR,
                `OFS_PULLUP: known_offset = 1'b1;
                default: known_offset = 1'b0;
            endcase
        end
    endfunction

    // divide codes give 2**code system clocks per conversion clock
    function [6:0] div_limit;
        input [2:0] code;
        begin
            if (code == `DIV_UNDEF)
                div_limit = 7'h7f;
            else
                div_limit = (7'h01 << code) - 7'h01;
        end
    endfunction

    wire wr_ctrl0 = wr_go & (aw_q == `OFS_CTRL0) & ws_q[0];
    wire wr_irq = wr_go & (aw_q == `OFS_IRQ) & ws_q[0];
    wire start_bit = ctrl0_q[`C0_START];
    wire power_off = ctrl0_q[`C0_PWR_OFF];
    wire tick = (div_cnt_q == div_limit(ctrl1_q[2:0]));

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid & ~aw_have_q)
            begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid & ~w_have_q)
            begin
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_offset(aw_q) ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; busy bit in ctrl0 is owned by the sequencer
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl0_q <= `RST_CTRL0;
            ctrl1_q <= `RST_CTRL1;
            pin_en_q <= `RST_PIN_EN;
            port_dir_q <= {PINS{1'b1}};
            pullup_q <= {PINS{1'b0}};
            conv_irq_en_q <= 1'b0;
            global_irq_en_q <= 1'b0;
        end
        else if (wr_go)
        begin
            if (wr_ctrl0)
                ctrl0_q <= w_q[7:0];
            if (aw_q == `OFS_CTRL1 && ws_q[0])
                ctrl1_q <= w_q[7:0];
            if (aw_q == `OFS_PIN_LO && ws_q[0])
                pin_en_q[7:0] <= w_q[7:0];
            if (aw_q == `OFS_PIN_HI && ws_q[0])
                pin_en_q[PINS-1:8] <= w_q[PINS-9:0];
            if (aw_q == `OFS_PORT_DIR && ws_q[0])
                port_dir_q[7:0] <= w_q[7:0];
            if (aw_q == `OFS_PORT_DIR && ws_q[1])
                port_dir_q[PINS-1:8] <= w_q[PINS-1:8];
            if (aw_q == `OFS_PULLUP && ws_q[0])
                pullup_q[7:0] <= w_q[7:0];
            if (aw_q == `OFS_PULLUP && ws_q[1])
                pullup_q[PINS-1:8] <= w_q[PINS-1:8];
            if (wr_irq)
            begin
                conv_irq_en_q <= w_q[`IRQ_CONV_EN];
                global_irq_en_q <= w_q[`IRQ_GLOBAL_EN];
            end
        end
    end

    // irq flag: hardware set wins over software clear
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_flag_q <= 1'b0;
        else if (irq_set)
            irq_flag_q <= 1'b1; // RULE14
        else if (wr_irq)
            irq_flag_q <= w_q[`IRQ_FLAG];
    end

    // conversion clock divider, held while the converter is reset
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            div_cnt_q <= 7'h00;
        else if (state_q != ST_CONV || tick)
            div_cnt_q <= 7'h00; // RULE5
        else
            div_cnt_q <= div_cnt_q + 7'h01; // RULE5
    end

    // behavioural transfer: input times 4096 over reference, saturated
    always @*
    begin
        conv_value = FULL;
        ref_level = supply_level_i;
        if (ctrl1_q[`C1_REF_SEL])
            ref_level = reference_pin_level_i;
        scaled = {analog_sample_i, {RES_W{1'b0}}}
            / {{RES_W{1'b0}}, ref_level}; // RULE16
        if (ref_level != {RES_W{1'b0}} && scaled < {{RES_W{1'b0}}, FULL})
            conv_value = scaled[RES_W-1:0]; // RULE15
    end

    // sequencer: rise of start arms and resets, fall begins conversion
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            period_q <= 5'h00;
            result_q <= {RES_W{1'b0}};
            irq_set <= 1'b0;
        end
        else
        begin
            irq_set <= 1'b0;
            case (state_q)
                ST_IDLE:
                    if (start_bit & ~power_off) // RULE19
                    begin
                        state_q <= ST_ARMED;
                        busy_q <= 1'b1; // RULE10
                    end
                ST_ARMED:
                    if (power_off)
                        state_q <= ST_IDLE; // RULE19
                    else if (~start_bit)
                    begin
                        state_q <= ST_CONV; // RULE9 RULE13
                        period_q <= 5'h00;
                    end
                ST_CONV:
                    if (power_off)
                        state_q <= ST_IDLE; // RULE6
                    else if (start_bit)
                        state_q <= ST_ARMED; // RULE10
                    else if (tick)
                    begin
                        if (period_q == `CONV_PERIODS - 5'h01)
                        begin
                            state_q <= ST_IDLE; // RULE12
                            busy_q <= 1'b0; // RULE11
                            result_q <= conv_value; // RULE15 RULE18
                            irq_set <= 1'b1; // RULE14
                        end
                        period_q <= period_q + 5'h01;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign irq_o = irq_flag_q & conv_irq_en_q & global_irq_en_q; // RULE8

    // pin and analog front-end control outputs
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            analog_pin_enable_o <= {PINS{1'b0}};
            pin_dir_input_o <= {PINS{1'b1}};
            pullup_enable_o <= {PINS{1'b0}};
            digital_func_enable_o <= {PINS{1'b1}};
            reference_select_o <= 1'b0;
            ref_pin_other_func_en_o <= 1'b1;
            channel_select_o <= 5'h00;
            converter_power_off_o <= 1'b1;
            converter_reset_o <= 1'b1;
            sample_strobe_o <= 1'b0;
            conv_clk_tick_o <= 1'b0;
        end
        else
        begin
            analog_pin_enable_o <= pin_en_q; // RULE1
            digital_func_enable_o <= ~pin_en_q; // RULE1
            pin_dir_input_o <= port_dir_q | pin_en_q; // RULE3
            pullup_enable_o <= pullup_q & ~pin_en_q; // RULE2
            reference_select_o <= ctrl1_q[`C1_REF_SEL]; // RULE4
            ref_pin_other_func_en_o <= ~ctrl1_q[`C1_REF_SEL]; // RULE4
            channel_select_o <= {ctrl1_q[`C1_CHAN_HI],
                ctrl0_q[`C0_CHAN_LO+3:`C0_CHAN_LO]}; // RULE7
            converter_power_off_o <= power_off; // RULE6
            converter_reset_o <= (state_q != ST_CONV); // RULE10
            sample_strobe_o <= (state_q == ST_ARMED) & ~start_bit
                & ~power_off;
            conv_clk_tick_o <= (state_q == ST_CONV) & tick;
        end
    end

    // read path
    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known_offset(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                `OFS_CTRL0: s_axi_rdata <= {24'h000000, start_bit,
                    busy_q, ctrl0_q[5:0]}; // RULE11
                `OFS_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_q};
                `OFS_PIN_LO: s_axi_rdata <= {24'h000000, pin_en_q[7:0]};
                `OFS_PIN_HI: s_axi_rdata <= {28'h0000000,
                    pin_en_q[PINS-1:8]};
                `OFS_IRQ: s_axi_rdata <= {29'h00000000, global_irq_en_q,
                    conv_irq_en_q, irq_flag_q};
                `OFS_RES_LO: s_axi_rdata <= {24'h000000, result_q[7:0]};
                `OFS_RES_HI: s_axi_rdata <= {28'h0000000,
                    result_q[RES_W-1:8]}; // RULE18
                `OFS_PORT_DIR: s_axi_rdata <= {20'h00000, port_dir_q};
                `OFS_PULLUP: s_axi_rdata <= {20'h00000, pullup_q};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule // adc_conversion_control
`default_nettype wire

// [adc_conversion_control_chk.sv]
// port assertions for the converter control
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_chk #(
    parameter PINS = 12
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [PINS-1:0] analog_pin_enable_o,
    input wire logic [PINS-1:0] pin_dir_input_o,
    input wire logic [PINS-1:0] pullup_enable_o,
    input wire logic [PINS-1:0] digital_func_enable_o,
    input wire logic reference_select_o,
    input wire logic ref_pin_other_func_en_o,
    input wire logic converter_power_off_o,
    input wire logic converter_reset_o,
    input wire logic sample_strobe_o,
    input wire logic conv_clk_tick_o
);
    logic [5:0] tick_q;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // conversion clock periods since the converter left reset
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            tick_q <= 6'h00;
        else if (converter_reset_o)
            tick_q <= 6'h00;
        else if (conv_clk_tick_o && !tick_q[5])
            tick_q <= tick_q + 6'h01;
    end
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_rd_hold: assert property (
        s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_pin_exclusive: assert property (
        digital_func_enable_o == ~analog_pin_enable_o)
        else $error("digital use left on analog pin");
    a_pullup_cut: assert property (
        (pullup_enable_o & analog_pin_enable_o) == {PINS{1'b0}})
        else $error("pullup on analog pin");
    a_dir_override: assert property (
        (analog_pin_enable_o & ~pin_dir_input_o) == {PINS{1'b0}})
        else $error("analog pin not input");
    a_ref_exclusive: assert property (
        ref_pin_other_func_en_o == !reference_select_o)
        else $error("reference pin shared use wrong");
    a_off_reset: assert property (
        converter_power_off_o |=> converter_reset_o)
        else $error("converter runs while off");
    a_conv_ticks: assert property (
        !converter_reset_o |-> tick_q < 6'h10)
        else $error("conversion longer than sixteen periods");
    a_strobe_pulse: assert property (
        sample_strobe_o |=> !converter_reset_o && !sample_strobe_o)
        else $error("sample strobe not a pulse");
endmodule // adc_conversion_control_chk
bind adc_conversion_control adc_conversion_control_chk #(
    .PINS(PINS)
) adc_conversion_control_chk_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .analog_pin_enable_o(analog_pin_enable_o),
    .pin_dir_input_o(pin_dir_input_o), .pullup_enable_o(pullup_enable_o),
    .digital_func_enable_o(digital_func_enable_o),
    .reference_select_o(reference_select_o),
    .ref_pin_other_func_en_o(ref_pin_other_func_en_o),
    .converter_power_off_o(converter_power_off_o),
    .converter_reset_o(converter_reset_o),
    .sample_strobe_o(sample_strobe_o), .conv_clk_tick_o(conv_clk_tick_o)
);
`default_nettype wire

// [adc_conversion_control_test.sv]
// self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defines.vh"
module adc_conversion_control_test;
    logic core_clk_i, sys_rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, dn;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_o;
    logic reference_select_o, ref_pin_other_func_en_o, converter_power_off_o;
    logic converter_reset_o, sample_strobe_o, conv_clk_tick_o;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp_q;
    logic [11:0] analog_sample_i, reference_pin_level_i, supply_level_i;
    logic [11:0] analog_pin_enable_o, pin_dir_input_o, pullup_enable_o;
    logic [11:0] digital_func_enable_o;
    logic [4:0] channel_select_o;
    integer err_count, num_checks, n, i;
    adc_conversion_control adc_conversion_control_i (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .analog_sample_i(analog_sample_i),
        .reference_pin_level_i(reference_pin_level_i),
        .supply_level_i(supply_level_i),
        .analog_pin_enable_o(analog_pin_enable_o),
        .pin_dir_input_o(pin_dir_input_o),
        .pullup_enable_o(pullup_enable_o),
        .digital_func_enable_o(digital_func_enable_o),
        .reference_select_o(reference_select_o),
        .ref_pin_other_func_en_o(ref_pin_other_func_en_o),
        .channel_select_o(channel_select_o),
        .converter_power_off_o(converter_power_off_o),
        .converter_reset_o(converter_reset_o),
        .sample_strobe_o(sample_strobe_o),
        .conv_clk_tick_o(conv_clk_tick_o), .irq_o(irq_o)
    );
    always #20 core_clk_i = ~core_clk_i;
    task print_verdict;
    begin
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            err_count = err_count + 1;
        end
    end
    endtask
    task hang;
    begin
        err_count = err_count + 1;
        print_verdict;
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge core_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        dn = 1'b0;
        for (n = 0; n < 60 && !dn; n = n + 1)
        begin
            @(posedge core_clk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            rsp_q = s_axi_bresp;
            dn = (s_axi_bvalid === 1'b1);
        end
        s_axi_bready <= 1'b0;
        if (!dn)
            hang;
    end
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
    begin
        @(posedge core_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        dn = 1'b0;
        for (n = 0; n < 60 && !dn; n = n + 1)
        begin
            @(posedge core_clk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            rd_q = s_axi_rdata;
            rsp_q = s_axi_rresp;
            dn = (s_axi_rvalid === 1'b1);
        end
        s_axi_rready <= 1'b0;
        if (!dn)
            hang;
        chk(rd_q, exp);
    end
    endtask
    task t_rst;
    begin
        rdc(`OFS_CTRL0, 32'h20);
        chk(analog_pin_enable_o, 12'hfff);
        chk(pullup_enable_o, 12'h000);
        chk(converter_reset_o, 1'b1);
    end
    endtask
    task t_pins;
    begin
        wr(`OFS_PULLUP, 32'hfff);
        wr(`OFS_PORT_DIR, 32'h0);
        wr(`OFS_PIN_LO, 32'h0f);
        wr(`OFS_PIN_HI, 32'h5);
        repeat (2) @(posedge core_clk_i);
        chk(analog_pin_enable_o, 12'h50f);
        chk(digital_func_enable_o, 12'haf0);
        chk(pullup_enable_o, 12'haf0);
        chk(pin_dir_input_o, 12'h50f);
    end
    endtask
    task t_ref(input [7:0] c1, input [7:0] c0, input [4:0] ch);
    begin
        wr(`OFS_CTRL1, c1);
        wr(`OFS_CTRL0, c0);
        repeat (2) @(posedge core_clk_i);
        chk(reference_select_o, c1[3]);
        chk(ref_pin_other_func_en_o, !c1[3]);
        chk(channel_select_o, ch);
        chk(converter_power_off_o, 1'b0);
    end
    endtask
    task t_conv(input [2:0] dv, input rs, input [11:0] s, input [11:0] e);
    begin
        analog_sample_i <= s;
        wr(`OFS_CTRL1, {rs, dv});
        wr(`OFS_IRQ, 32'h0);
        wr(`OFS_CTRL0, 32'h83);
        rdc(`OFS_CTRL0, 32'hc3);
        wr(`OFS_CTRL0, 32'h03);
        dn = 1'b0;
        i = 0;
        while (i < 3000 && !(dn && converter_reset_o === 1'b1))
        begin
            @(posedge core_clk_i);
            dn = dn | (converter_reset_o === 1'b0);
            i = i + 1;
        end
        if (i == 3000)
            hang;
        chk(i >= (16 << dv) && i <= (16 << dv) + 4, 1);
        // the result must not follow the input after completion
        analog_sample_i <= ~s;
        rdc(`OFS_CTRL0, 32'h03);
        rdc(`OFS_RES_LO, e[7:0]);
        rdc(`OFS_RES_HI, e[11:8]);
        rdc(`OFS_IRQ, 32'h1);
        chk(irq_o, 1'b0);
    end
    endtask
    task t_irq;
    begin
        wr(`OFS_IRQ, 32'h3);
        chk(irq_o, 1'b0);
        wr(`OFS_IRQ, 32'h5);
        chk(irq_o, 1'b0);
        wr(`OFS_IRQ, 32'h7);
        chk(irq_o, 1'b1);
        wr(`OFS_IRQ, 32'h6);
        chk(irq_o, 1'b0);
    end
    endtask
    task t_off;
    begin
        wr(`OFS_CTRL0, 32'ha3);
        rdc(`OFS_CTRL0, 32'ha3);
        chk(converter_reset_o, 1'b1);
        wr(`OFS_CTRL0, 32'h23);
        rdc(`OFS_CTRL0, 32'h23);
        wr(8'h40, 32'h1);
        chk(rsp_q, 2'h2);
        rdc(8'h40, 32'h0);
        chk(rsp_q, 2'h2);
    end
    endtask
    initial
    begin
        {core_clk_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        analog_sample_i = 12'h0;
        reference_pin_level_i = 12'h800;
        supply_level_i = 12'hfff;
        sys_rst_i = 1'b1;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_rst;
        t_pins;
        t_ref(8'h88, 8'h03, 5'h13);
        t_ref(8'h00, 8'h0c, 5'h0c);
        t_conv(3'h0, 1'b0, 12'h123, 12'h123);
        t_conv(3'h3, 1'b1, 12'h9ab, 12'hfff);
        t_conv(3'h6, 1'b1, 12'h7ff, 12'hffe);
        t_conv(3'h7, 1'b0, 12'h800, 12'h800);
        t_irq;
        t_off;
        print_verdict;
    end
endmodule // adc_conversion_control_test
`default_nettype wire

// [adc_ctrl_defines.vh]
// register map, field positions and reset values of the converter control
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_PIN_LO 8'h08
`define OFS_PIN_HI 8'h0c
`define OFS_IRQ 8'h10
`define OFS_RES_LO 8'h14
`define OFS_RES_HI 8'h18
`define OFS_PORT_DIR 8'h1c
`define OFS_PULLUP 8'h20
`define C0_CHAN_LO 0
`define C0_PWR_OFF 5
`define C0_BUSY 6
`define C0_START 7
`define C1_DIV_LO 0
`define C1_REF_SEL 3
`define C1_CHAN_HI 7
`define IRQ_FLAG 0
`define IRQ_CONV_EN 1
`define IRQ_GLOBAL_EN 2
`define RST_CTRL0 8'h60
`define RST_CTRL1 8'h00
`define RST_PIN_EN 12'hfff
`define CONV_PERIODS 5'h10
`define DIV_UNDEF 3'h7
`endif
